// ### design/scflg_top.sv
/*
 * scflg_top: status flags of a serial channel in smart card
 * mode (parity fault, transmit finished, multiprocessor bits)
 * with a small register port and one level interrupt.
 * Assumes the receiver, transmitter and bit-rate generator sit
 * outside and pulse their events synchronously to CLK_I.
 */
`timescale 1ns/1ps
// What this block does
// - parity error sets parity fault flag bit 3
// - errored char still stored, rx full not set
// - no char stored while parity fault set
// - parity fault cleared by write 0 after read
// - receiver disable leaves parity fault alone
// - transmit finished bit 2, read only, reset one
// - finished set when tx off or timed check
// - no guard, no block: 2.5 etu
// - no guard, block mode: 1.5 etu
// - guard mode: 1.0 etu always
// - finished cleared by clearing tx empty flag
// - etu equals one bit time for delays
// - multiproc rx bit reads zero, read only
// - writing one sets no flag but multiproc tx bit 0
// - low error signal sets error signal flag
// - tx empty set when tx off or loaded
module scflg_top (
   input  wire logic       CLK_I,
   input  wire logic       RST_I,
   input  wire logic       CE_I,
   input  wire logic [2:0] ADDR_I,
   input  wire logic [7:0] WDATA_I,
   input  wire logic       WE_I,
   input  wire logic       RE_I,
   input  wire logic       HALF_ETU_TICK_I,
   input  wire logic       TX_START_I,
   input  wire logic       TX_LOAD_I,
   input  wire logic       ERR_SAMPLE_I,
   input  wire logic       LINE_I,
   input  wire logic       RX_DONE_I,
   input  wire logic       RX_PAR_ERR_I,
   input  wire logic [7:0] RX_CHAR_I,
   output logic      [7:0] RDATA_O,
   output logic      [7:0] TX_CHAR_O,
   output logic            TX_ON_O,
   output logic            RX_ON_O,
   output logic            GUARD_O,
   output logic            BLOCK_O,
   output logic            IRQ_O
);
   import scflg_pkg::*;

   function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
      return a == off;
   endfunction

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   logic          par_q;
   logic          transmit_finished_flag_q;
   logic          ers_q;
   logic          rx_holding_full_q;
   logic          tx_holding_empty_q;
   logic          multiproc_tx_bit_q;
   logic [7:0]    armed_q;
   logic [7:0]    ctrl_q;
   logic [7:0]    txh_q;
   logic [7:0]    rxh_q;
   logic [3:0]    isr_q;
   logic [3:0]    imr_q;
   logic [2:0]    cnt_q;
   scflg_tstate_t ts_q;
   logic [7:0]    status;
   logic          wr_st;
   logic          clr_par;
   logic          clr_ers;
   logic          clr_rx_holding_full;
   logic          clr_tx_holding_empty;
   logic          rx_take;
   logic          set_par;
   logic          set_rx_holding_full;
   logic          set_ers;
   logic          time_up;
   logic          set_transmit_finished_flag;
   logic [2:0]    target;

   // -----------------------------------------------------------------
   // status image and clear decode
   // -----------------------------------------------------------------
   always_comb begin
      status         = RST_BYTE;
      status[B_TX_HOLDING_EMPTY] = tx_holding_empty_q;
      status[B_RX_HOLDING_FULL] = rx_holding_full_q;
      status[B_ERS]  = ers_q;
      status[B_PER]  = par_q;
      status[B_TRANSMIT_FINISHED_FLAG] = transmit_finished_flag_q;
      status[B_MPB]  = 1'b0;
      status[B_MULTIPROC_TX_BIT] = multiproc_tx_bit_q;
   end

   assign wr_st = WE_I && hit(ADDR_I, OFF_STATUS);
   // a one written never sets; zero clears only once read as one
   assign clr_par  = wr_st && !WDATA_I[B_PER] && armed_q[B_PER];
   assign clr_ers  = wr_st && !WDATA_I[B_ERS] && armed_q[B_ERS];
   assign clr_rx_holding_full = wr_st && !WDATA_I[B_RX_HOLDING_FULL] && armed_q[B_RX_HOLDING_FULL];
   assign clr_tx_holding_empty = wr_st && !WDATA_I[B_TX_HOLDING_EMPTY] && armed_q[B_TX_HOLDING_EMPTY];

   // -----------------------------------------------------------------
   // receive side
   // -----------------------------------------------------------------
   // receiver enable gates new events only, never the flag itself
   assign rx_take  = RX_DONE_I && ctrl_q[C_RXON] && !par_q;
   assign set_par  = rx_take && RX_PAR_ERR_I;
   assign set_rx_holding_full = rx_take && !RX_PAR_ERR_I;

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         rxh_q <= RST_BYTE;
      end else if (CE_I && rx_take) begin
         rxh_q <= RX_CHAR_I;
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         par_q <= 1'b0;
      end else if (CE_I) begin
         if (set_par) begin
            par_q <= 1'b1;
         end else if (clr_par) begin
            par_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         rx_holding_full_q <= 1'b0;
      end else if (CE_I) begin
         if (set_rx_holding_full) begin
            rx_holding_full_q <= 1'b1;
         end else if (clr_rx_holding_full) begin
            rx_holding_full_q <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // error signal and transmit empty
   // -----------------------------------------------------------------
   assign set_ers = ERR_SAMPLE_I && !LINE_I;

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ers_q <= 1'b0;
      end else if (CE_I) begin
         if (set_ers) begin
            ers_q <= 1'b1;
         end else if (clr_ers) begin
            ers_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         tx_holding_empty_q <= RST_TX_HOLDING_EMPTY;
      end else if (CE_I) begin
         if (!ctrl_q[C_TXON] || TX_LOAD_I) begin
            tx_holding_empty_q <= 1'b1;
         end else if (clr_tx_holding_empty) begin
            tx_holding_empty_q <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // transmit finished timing
   // -----------------------------------------------------------------
   // delays counted in half etu so 2.5 and 1.5 stay exact
   always_comb begin
      if (ctrl_q[C_GUARD]) begin
         target = HALF_1P0;
      end else if (ctrl_q[C_BLOCK]) begin
         target = HALF_1P5;
      end else begin
         target = HALF_2P5;
      end
   end

   assign time_up  = (ts_q == T_COUNT) && HALF_ETU_TICK_I && (cnt_q + 3'h1 == target);
   assign set_transmit_finished_flag = !ctrl_q[C_TXON] || (time_up && !ers_q && tx_holding_empty_q);

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ts_q  <= T_IDLE;
         cnt_q <= RST_CNT;
      end else if (CE_I) begin
         if (TX_START_I && ctrl_q[C_TXON]) begin
            ts_q  <= T_COUNT;
            cnt_q <= RST_CNT;
         end else begin
            unique case (ts_q)
               T_IDLE: begin
                  cnt_q <= RST_CNT;
               end
               T_COUNT: begin
                  if (!ctrl_q[C_TXON] || time_up) begin
                     ts_q <= T_IDLE;
                  end else if (HALF_ETU_TICK_I) begin
                     cnt_q <= cnt_q + 3'h1;
                  end
               end
               default: begin
                  ts_q <= T_IDLE;
               end
            endcase
         end
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         transmit_finished_flag_q <= RST_TRANSMIT_FINISHED_FLAG;
      end else if (CE_I) begin
         if (set_transmit_finished_flag) begin
            transmit_finished_flag_q <= 1'b1;
         end else if (clr_tx_holding_empty) begin
            transmit_finished_flag_q <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // software registers
   // -----------------------------------------------------------------
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         armed_q <= RST_BYTE;
      end else if (CE_I) begin
         if (RE_I && hit(ADDR_I, OFF_STATUS)) begin
            armed_q <= status;
         end else if (wr_st) begin
            armed_q <= RST_BYTE;
         end
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         multiproc_tx_bit_q <= 1'b0;
      end else if (CE_I && wr_st) begin
         // plain storage; software keeps it at zero here
         multiproc_tx_bit_q <= WDATA_I[B_MULTIPROC_TX_BIT];
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ctrl_q <= RST_BYTE;
         txh_q  <= RST_BYTE;
         imr_q  <= 4'h0;
      end else if (CE_I && WE_I) begin
         if (hit(ADDR_I, OFF_CTRL)) begin
            ctrl_q <= {4'h0, WDATA_I[3:0]};
         end
         if (hit(ADDR_I, OFF_TXHOLD)) begin
            txh_q <= WDATA_I;
         end
         if (hit(ADDR_I, OFF_IRQMASK)) begin
            imr_q <= WDATA_I[3:0];
         end
      end
   end

   // -----------------------------------------------------------------
   // interrupt status, one written clears, new event wins
   // -----------------------------------------------------------------
   logic [3:0] ev;
   logic [3:0] w1c;
   assign ev[I_PER]  = set_par;
   assign ev[I_TRANSMIT_FINISHED_FLAG] = set_transmit_finished_flag && !transmit_finished_flag_q;
   assign ev[I_ERS]  = set_ers;
   assign ev[I_RX_HOLDING_FULL] = set_rx_holding_full;
   assign w1c = (WE_I && hit(ADDR_I, OFF_IRQSTAT)) ? WDATA_I[3:0] : 4'h0;

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         isr_q <= 4'h0;
         IRQ_O <= 1'b0;
      end else if (CE_I) begin
         isr_q <= ev | (isr_q & ~w1c);
         IRQ_O <= |((ev | (isr_q & ~w1c)) & imr_q);
      end
   end

   // -----------------------------------------------------------------
   // read data and registered outputs
   // -----------------------------------------------------------------
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         RDATA_O <= RST_BYTE;
      end else if (CE_I) begin
         RDATA_O <= RST_BYTE;
         if (RE_I) begin
            unique case (ADDR_I)
               OFF_STATUS:  RDATA_O <= status;
               OFF_CTRL:    RDATA_O <= ctrl_q;
               OFF_TXHOLD:  RDATA_O <= txh_q;
               OFF_RXHOLD:  RDATA_O <= rxh_q;
               OFF_IRQSTAT: RDATA_O <= {4'h0, isr_q};
               OFF_IRQMASK: RDATA_O <= {4'h0, imr_q};
               default:     RDATA_O <= RST_BYTE;
            endcase
         end
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         TX_CHAR_O <= RST_BYTE;
         TX_ON_O   <= 1'b0;
         RX_ON_O   <= 1'b0;
         GUARD_O   <= 1'b0;
         BLOCK_O   <= 1'b0;
      end else if (CE_I) begin
         TX_CHAR_O <= txh_q;
         TX_ON_O   <= ctrl_q[C_TXON];
         RX_ON_O   <= ctrl_q[C_RXON];
         GUARD_O   <= ctrl_q[C_GUARD];
         BLOCK_O   <= ctrl_q[C_BLOCK];
      end
   end

endmodule // scflg_top

// ### design/scflg_pkg.sv
/*
 * scflg_pkg: offsets, field positions, reset values and etu
 * delay counts for the smart card status flag block.
 * Assumes one system clock and a half-etu tick from the
 * bit-rate generator outside.
 */
package scflg_pkg;
   // -----------------------------------------------------------------
   // register offsets
   // -----------------------------------------------------------------
   localparam logic [2:0] OFF_STATUS  = 3'h0;
   localparam logic [2:0] OFF_CTRL    = 3'h1;
   localparam logic [2:0] OFF_TXHOLD  = 3'h2;
   localparam logic [2:0] OFF_RXHOLD  = 3'h3;
   localparam logic [2:0] OFF_IRQSTAT = 3'h4;
   localparam logic [2:0] OFF_IRQMASK = 3'h5;
   // -----------------------------------------------------------------
   // status field positions
   // -----------------------------------------------------------------
   localparam int B_TX_HOLDING_EMPTY = 7;
   localparam int B_RX_HOLDING_FULL = 6;
   localparam int B_ERS  = 4;
   localparam int B_PER  = 3;
   localparam int B_TRANSMIT_FINISHED_FLAG = 2;
   localparam int B_MPB  = 1;
   localparam int B_MULTIPROC_TX_BIT = 0;
   // -----------------------------------------------------------------
   // control field positions
   // -----------------------------------------------------------------
   localparam int C_TXON  = 0;
   localparam int C_RXON  = 1;
   localparam int C_GUARD = 2;
   localparam int C_BLOCK = 3;
   // -----------------------------------------------------------------
   // interrupt event positions
   // -----------------------------------------------------------------
   localparam int I_PER  = 0;
   localparam int I_TRANSMIT_FINISHED_FLAG = 1;
   localparam int I_ERS  = 2;
   localparam int I_RX_HOLDING_FULL = 3;
   // -----------------------------------------------------------------
   // reset values and delays in half-etu ticks
   // -----------------------------------------------------------------
   localparam logic [7:0] RST_BYTE  = 8'h00;
   localparam logic       RST_TRANSMIT_FINISHED_FLAG  = 1'b1;
   localparam logic       RST_TX_HOLDING_EMPTY  = 1'b1;
   localparam logic [2:0] HALF_2P5  = 3'h5;
   localparam logic [2:0] HALF_1P5  = 3'h3;
   localparam logic [2:0] HALF_1P0  = 3'h2;
   localparam logic [2:0] RST_CNT   = 3'h0;
   typedef enum logic [1:0] {
      T_IDLE  = 2'b01,
      T_COUNT = 2'b10
   } scflg_tstate_t;
endpackage

// ### bench/scflg_checker.sv
/* scflg_checker: port assertions for scflg_top.
   assumes it is bound to scflg_top and runs on its one clock. */
`timescale 1ns/1ps
module scflg_checker import scflg_pkg::*; (
   input wire logic       CLK_I,
   input wire logic       RST_I,
   input wire logic       CE_I,
   input wire logic [2:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic       WE_I,
   input wire logic       RE_I,
   input wire logic [7:0] RDATA_O,
   input wire logic [7:0] TX_CHAR_O,
   input wire logic       TX_ON_O,
   input wire logic       IRQ_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   wire rd_st = CE_I && RE_I && ADDR_I == OFF_STATUS;
   a_rdata_idle: assert property (CE_I && !RE_I |=> RDATA_O == 8'h00)
      else $error("read data not zero outside a read");
   a_mpb_zero: assert property (rd_st |=> !RDATA_O[B_MPB])
      else $error("multiproc rx bit read as one");
   // tx off for a whole cycle before the read, so both flags must be up
   a_transmit_finished_flag_txoff: assert property (rd_st && !TX_ON_O && $past(CE_I) |=> RDATA_O[B_TRANSMIT_FINISHED_FLAG] && RDATA_O[B_TX_HOLDING_EMPTY])
      else $error("finished or empty flag low with tx off");
   a_unmapped_zero: assert property (CE_I && RE_I && ADDR_I[2:1] == 2'b11 |=> RDATA_O == 8'h00)
      else $error("unmapped read not zero");
   a_freeze_hold: assert property (!CE_I |=> $stable(RDATA_O) && $stable(IRQ_O) && $stable(TX_ON_O))
      else $error("outputs moved while clock enable low");
   a_ctrl_copy: assert property (CE_I && WE_I && ADDR_I == OFF_CTRL ##1 CE_I [*2]
      |-> TX_ON_O == $past(WDATA_I[C_TXON], 2))
      else $error("tx on output does not follow control write");
   a_txchar_copy: assert property (CE_I && WE_I && ADDR_I == OFF_TXHOLD ##1 CE_I [*2]
      |-> TX_CHAR_O == $past(WDATA_I, 2))
      else $error("tx char output does not follow holding write");
   a_irq_masked: assert property (CE_I && WE_I && ADDR_I == OFF_IRQMASK && WDATA_I == 8'h00
      ##1 CE_I && !WE_I ##1 CE_I |-> !IRQ_O)
      else $error("interrupt high with all masked");
   c_per_read: cover property (rd_st ##1 RDATA_O[B_PER]);
   c_irq_up: cover property ($rose(IRQ_O));
   c_freeze: cover property (!CE_I [*3]);
endmodule // scflg_checker

bind scflg_top scflg_checker u_scflg_checker (.CLK_I(CLK_I), .RST_I(RST_I), .CE_I(CE_I), .ADDR_I(ADDR_I),
   .WDATA_I(WDATA_I), .WE_I(WE_I), .RE_I(RE_I), .RDATA_O(RDATA_O), .TX_CHAR_O(TX_CHAR_O),
   .TX_ON_O(TX_ON_O), .IRQ_O(IRQ_O));

// ### bench/scflg_card.sv
/* scflg_card: card model plus half-etu tick source.
   assumes the bench pulses send_i and raises nack_i at the error sample. */
`timescale 1ns/1ps
module scflg_card #(parameter int HALF = 8) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       nack_i,
   input  wire logic       send_i,
   input  wire logic       par_i,
   input  wire logic [7:0] char_i,
   output logic            tick_o,
   output wire logic       line_o,
   output logic            done_o,
   output logic            perr_o,
   output wire logic [7:0] char_o
);
   int         cnt_q;
   logic       pend_q;
   logic [7:0] c_q;
   // pull-up holds the line high unless the card signals an error
   assign line_o = !nack_i;
   // outside the strobe the bus shows garbage, not the last char
   assign char_o = done_o ? c_q : ~c_q;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q <= 0;
         tick_o <= 1'b0;
         pend_q <= 1'b0;
         done_o <= 1'b0;
         perr_o <= 1'b0;
         c_q <= 8'h00;
      end else begin
         cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
         tick_o <= cnt_q == HALF - 1;
         done_o <= pend_q && tick_o;
         if (pend_q && tick_o) begin
            pend_q <= 1'b0;
         end
         if (send_i) begin
            pend_q <= 1'b1;
            c_q <= char_i;
            perr_o <= par_i;
         end
      end
   end
endmodule // scflg_card

// ### bench/tb.sv
/* tb: self-checking bench for scflg_top with the card model.
   assumes a 100 MHz clock and a half-etu tick every 8 cycles. */
`timescale 1ns/1ps
module tb;
   import scflg_pkg::*;
   logic       CLK_I = 1'b0;
   logic       RST_I = 1'b1;
   logic       CE_I = 1'b1;
   logic       WE_I = 1'b0;
   logic       RE_I = 1'b0;
   logic       TX_START_I = 1'b0;
   logic       TX_LOAD_I = 1'b0;
   logic       ERR_SAMPLE_I = 1'b0;
   logic [2:0] ADDR_I = 3'h0;
   logic [7:0] WDATA_I = 8'h00;
   logic       nack = 1'b0;
   logic       snd = 1'b0;
   logic       sp = 1'b0;
   logic [7:0] sc = 8'h00;
   wire        HALF_ETU_TICK_I, LINE_I, RX_DONE_I, RX_PAR_ERR_I, TX_ON_O, RX_ON_O, GUARD_O, BLOCK_O, IRQ_O;
   wire  [7:0] RX_CHAR_I, RDATA_O, TX_CHAR_O;
   int         err_total = 0;
   int         n_tests = 0;
   int         seed = 32'hdde6;
   int         k;
   logic [7:0] c, d, v;
   logic       g, b, nk;
   always #5 CLK_I = ~CLK_I;
   scflg_top u_scflg_top (.CLK_I(CLK_I), .RST_I(RST_I), .CE_I(CE_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
      .WE_I(WE_I), .RE_I(RE_I), .HALF_ETU_TICK_I(HALF_ETU_TICK_I), .TX_START_I(TX_START_I),
      .TX_LOAD_I(TX_LOAD_I), .ERR_SAMPLE_I(ERR_SAMPLE_I), .LINE_I(LINE_I), .RX_DONE_I(RX_DONE_I),
      .RX_PAR_ERR_I(RX_PAR_ERR_I), .RX_CHAR_I(RX_CHAR_I), .RDATA_O(RDATA_O), .TX_CHAR_O(TX_CHAR_O),
      .TX_ON_O(TX_ON_O), .RX_ON_O(RX_ON_O), .GUARD_O(GUARD_O), .BLOCK_O(BLOCK_O), .IRQ_O(IRQ_O));
   scflg_card #(.HALF(8)) u_scflg_card (.clk_i(CLK_I), .rst_i(RST_I), .nack_i(nack), .send_i(snd),
      .par_i(sp), .char_i(sc), .tick_o(HALF_ETU_TICK_I), .line_o(LINE_I), .done_o(RX_DONE_I),
      .perr_o(RX_PAR_ERR_I), .char_o(RX_CHAR_I));
   // two half ticks make one etu
   function automatic int ticks(input logic gm, input logic bm);
      return gm ? 2 : (bm ? 3 : 5);
   endfunction
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      n_tests++;
      if (s !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] dv);
      @(posedge CLK_I);
      WE_I <= 1'b1;
      ADDR_I <= a;
      WDATA_I <= dv;
      @(posedge CLK_I);
      WE_I <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] dv);
      @(posedge CLK_I);
      RE_I <= 1'b1;
      ADDR_I <= a;
      @(posedge CLK_I);
      RE_I <= 1'b0;
      #1 dv = RDATA_O;
   endtask
   task automatic st(input logic [7:0] m, input logic [7:0] e, input string n);
      logic [7:0] s;
      rd(OFF_STATUS, s);
      chk(n, s & m, e);
   endtask
   task automatic send(input logic [7:0] ch, input logic p);
      @(posedge CLK_I);
      snd <= 1'b1;
      sc <= ch;
      sp <= p;
      @(posedge CLK_I);
      snd <= 1'b0;
      @(posedge RX_DONE_I);
      @(posedge CLK_I);
   endtask
   task automatic tk(input int n);
      repeat (n) begin
         @(posedge CLK_I);
         while (HALF_ETU_TICK_I !== 1'b1) @(posedge CLK_I);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge CLK_I);
      err_total++;
      tally_and_finish;
   end
   initial begin
      repeat (5) @(posedge CLK_I);
      RST_I <= 1'b0;
      st(8'hFF, 8'h84, "reset_status");
      rd(3'h6, v);
      chk("unmapped6", v, 8'h00);
      rd(3'h7, v);
      chk("unmapped7", v, 8'h00);
      $display("test reset done");
      wr(OFF_IRQMASK, 8'h00);
      wr(OFF_CTRL, 8'h02);
      c = 8'($random(seed));
      send(c, 1'b0);
      st(8'h48, 8'h40, "rx_holding_full_set");
      chk("rx_on_out", {7'h0, RX_ON_O}, 8'h01);
      rd(OFF_RXHOLD, v);
      chk("rx_char", v, c);
      wr(OFF_STATUS, 8'hBE);
      d = 8'($random(seed));
      send(d, 1'b1);
      st(8'h48, 8'h08, "per_set");
      send(~d, 1'b0);
      st(8'h48, 8'h08, "per_blocks");
      wr(OFF_RXHOLD, c);
      rd(OFF_RXHOLD, v);
      chk("rx_hold", v, d);
      chk("irq_masked", {7'h0, IRQ_O}, 8'h00);
      wr(OFF_IRQMASK, 8'h01 << I_PER);
      @(posedge CLK_I);
      #1 chk("irq_raise", {7'h0, IRQ_O}, 8'h01);
      wr(OFF_IRQSTAT, 8'h01 << I_PER);
      @(posedge CLK_I);
      #1 chk("irq_clear", {7'h0, IRQ_O}, 8'h00);
      wr(OFF_CTRL, 8'h00);
      wr(OFF_STATUS, 8'hFE);
      st(8'h18, 8'h08, "per_kept");
      wr(OFF_STATUS, 8'hFE);
      wr(OFF_STATUS, 8'hF6);
      st(8'h08, 8'h08, "per_unarmed");
      wr(OFF_STATUS, 8'hF6);
      st(8'h08, 8'h00, "per_clear");
      $display("test receive done");
      for (k = 0; k < 5; k++) begin
         g = k[1];
         b = k[0];
         nk = k == 4;
         wr(OFF_CTRL, {4'h0, b, g, 2'b01});
         st(8'h80, 8'h80, "tx_holding_empty_set");
         chk("ctrl_out", {4'h0, BLOCK_O, GUARD_O, RX_ON_O, TX_ON_O}, {4'h0, b, g, 2'b01});
         wr(OFF_STATUS, 8'h7E);
         st(8'h84, 8'h00, "transmit_finished_flag_clear");
         tk(1);
         TX_LOAD_I <= 1'b1;
         TX_START_I <= 1'b1;
         @(posedge CLK_I);
         TX_LOAD_I <= 1'b0;
         TX_START_I <= 1'b0;
         tk(ticks(g, b) - 1);
         ERR_SAMPLE_I <= 1'b1;
         nack <= nk;
         @(posedge CLK_I);
         ERR_SAMPLE_I <= 1'b0;
         nack <= 1'b0;
         st(8'h14, {3'h0, nk, 4'h0}, "transmit_finished_flag_early");
         tk(1);
         st(8'h14, {3'h0, nk, 1'b0, !nk, 2'h0}, "transmit_finished_flag_time");
         wr(OFF_STATUS, 8'hEE);
      end
      wr(OFF_CTRL, 8'h00);
      st(8'h84, 8'h84, "txoff_set");
      // parity event was cleared by its one-write, the rest stay sticky
      rd(OFF_IRQSTAT, v);
      chk("irq_status", v, (8'h01 << I_TRANSMIT_FINISHED_FLAG) | (8'h01 << I_ERS) | (8'h01 << I_RX_HOLDING_FULL));
      $display("test transmit done");
      c = 8'($random(seed));
      wr(OFF_TXHOLD, c);
      repeat (2) @(posedge CLK_I);
      // a write while frozen must be lost
      CE_I <= 1'b0;
      wr(OFF_TXHOLD, ~c);
      @(posedge CLK_I);
      CE_I <= 1'b1;
      chk("tx_char_frozen", TX_CHAR_O, c);
      @(posedge CLK_I);
      #1 chk("tx_char", TX_CHAR_O, c);
      $display("test freeze done");
      tally_and_finish;
   end
endmodule // tb
